// [core/ccr_defs.vh]
// Purpose: Constants for the charger configuration register bank
// Assumes: Byte-wide registers on a simple write/read port
// Notes:   Defaults of the supply-reset fields are plain choices
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH

// Register addresses
`define CCR_ADDR_ILIM     8'h0f
`define CCR_ADDR_CTRL_A   8'h10
`define CCR_ADDR_CTRL_B   8'h11
`define CCR_ADDR_TIMER    8'h12
`define CCR_ADDR_STEP_A   8'h13

// Reset values
`define CCR_RST_ILIM      8'h00
`define CCR_RST_CTRL_A    8'h00
`define CCR_RST_CTRL_B    8'h00
`define CCR_RST_TIMER     8'h40
`define CCR_RST_STEP_A    8'h00

// Writable bit masks
`define CCR_MASK_ILIM     8'hff
`define CCR_MASK_FULL     8'hff
`define CCR_MASK_STEP_A   8'h7f

// Field positions
`define CCR_ILIM_HI       2
`define CCR_ILIM_LO       0
`define CCR_EN_BIT        0
`define CCR_FRC_PCHG_BIT  7
`define CCR_PULLDOWN_BIT  7
`define CCR_PRECHARGE_RISE_THRESHOLD_HI      6
`define CCR_PRECHARGE_RISE_THRESHOLD_LO      4
`define CCR_DONE_HI       1
`define CCR_DONE_LO       0
`define CCR_RESTART_BIT   6

// Supply-valid option codes
`define CCR_OPT_BOTH      2'h0
`define CCR_OPT_RISE      2'h1
`define CCR_OPT_FALL      2'h2
`define CCR_OPT_NONE      2'h3

// Code tables: limit in mA, threshold in 10 mV, ratio in percent
`define CCR_ILIM_TABLE    {10'd1000, 10'd450, 10'd400, 10'd300, \
                           10'd200, 10'd150, 10'd90, 10'd50}
`define CCR_VP_BASE       9'd210
`define CCR_VP_STEP       9'd15
`define CCR_DONE_TABLE    {5'd30, 5'd20, 5'd10, 5'd5}

`endif

// [core/ccr_regs.v]
// Purpose: Charger configuration registers and their decoded outputs
// Assumes: Serial control port already turned into byte write/read strobes
// Notes:   Supply edges reload defaults, gated by the supply-valid option
//
// Operation
// - Decode 3-bit input current limit code
// - Supply edges restore field defaults per option
// - Control B bit 7 drives battery pulldown
// - Precharge threshold 2.10 V to 3.15 V
// - Termination current ratio from 2-bit code
// - Auto-restart bit permits recharge from done
`default_nettype none
`include "ccr_defs.vh"
module ccr_regs (
  // Clock and reset
  input  wire       I_CORE_CLK,
  input  wire       I_RSTN,
  // Register port
  input  wire       i_wr_en,
  input  wire       i_rd_en,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  output reg        o_rd_valid,
  // Charger supply and option
  input  wire       i_charger_supply_input,
  input  wire [1:0] i_supply_valid_reset_option,
  // Charger state inputs
  input  wire       i_maint_done,
  input  wire       i_vbat_below_recharge,
  // Decoded controls
  output reg  [2:0] o_input_current_limit_sel,
  output reg  [9:0] o_input_limit_ma,
  output reg        o_battery_pulldown_enable,
  output reg  [8:0] o_precharge_rise_10mv,
  output reg  [4:0] o_termination_pct,
  output reg        o_charger_enable,
  output reg        o_force_precharge_current,
  output reg        o_restart_request
);
  reg  [7:0] ilim_q;
  reg  [7:0] ctrl_a_q;
  reg  [7:0] ctrl_b_q;
  reg  [7:0] timer_q;
  reg  [7:0] step_a_q;
  reg        supply_prev_q;
  reg        supply_seen_q;
  wire       supply_lvl;
  reg        supply_reset;
  wire [79:0] ilim_table = `CCR_ILIM_TABLE;
  wire [19:0] done_table = `CCR_DONE_TABLE;
  wire [2:0]  ilim_code;
  wire [2:0]  vp_code;
  wire [1:0]  done_code;

  // Supply pin is asynchronous to the core clock
  ccr_sync3 u_supply_sync (
    .i_clk   (I_CORE_CLK),
    .i_rstn  (I_RSTN),
    .i_async (i_charger_supply_input),
    .o_level (supply_lvl)
  );

  // Edge memory; first sample after reset is not taken as an edge
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      supply_prev_q <= 1'b0;
      supply_seen_q <= 1'b0;
    end else begin
      supply_prev_q <= supply_lvl;
      supply_seen_q <= 1'b1;
    end
  end

  // Edge qualified by the option code
  always @* begin
    supply_reset = 1'b0;
    if (supply_seen_q) begin
      case (i_supply_valid_reset_option)
        `CCR_OPT_BOTH: supply_reset = supply_lvl ^ supply_prev_q;
        `CCR_OPT_RISE: supply_reset = supply_lvl & ~supply_prev_q;
        `CCR_OPT_FALL: supply_reset = ~supply_lvl & supply_prev_q;
        `CCR_OPT_NONE: supply_reset = 1'b0;
        default:       supply_reset = 1'b0;
      endcase
    end
  end

  // Register storage; the supply reset beats a write in the same cycle
  // so the charger never runs on stale settings after a plug event
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ilim_q   <= `CCR_RST_ILIM;
      ctrl_a_q <= `CCR_RST_CTRL_A;
      ctrl_b_q <= `CCR_RST_CTRL_B;
      timer_q  <= `CCR_RST_TIMER;
      step_a_q <= `CCR_RST_STEP_A;
    end else if (supply_reset) begin
      ilim_q   <= `CCR_RST_ILIM;
      ctrl_a_q <= `CCR_RST_CTRL_A;
      ctrl_b_q <= `CCR_RST_CTRL_B;
      timer_q  <= `CCR_RST_TIMER;
      step_a_q <= `CCR_RST_STEP_A;
    end else if (i_wr_en) begin
      case (i_addr)
        `CCR_ADDR_ILIM:   ilim_q   <= i_wdata & `CCR_MASK_ILIM;
        `CCR_ADDR_CTRL_A: ctrl_a_q <= i_wdata & `CCR_MASK_FULL;
        `CCR_ADDR_CTRL_B: ctrl_b_q <= i_wdata & `CCR_MASK_FULL;
        `CCR_ADDR_TIMER:  timer_q  <= i_wdata & `CCR_MASK_FULL;
        `CCR_ADDR_STEP_A: step_a_q <= i_wdata & `CCR_MASK_STEP_A;
        default:          ilim_q   <= ilim_q;
      endcase
    end
  end

  // Read port, one cycle latency; unmapped addresses read zero
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      o_rdata    <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        case (i_addr)
          `CCR_ADDR_ILIM:   o_rdata <= ilim_q;
          `CCR_ADDR_CTRL_A: o_rdata <= ctrl_a_q;
          `CCR_ADDR_CTRL_B: o_rdata <= ctrl_b_q;
          `CCR_ADDR_TIMER:  o_rdata <= timer_q;
          `CCR_ADDR_STEP_A: o_rdata <= step_a_q;
          default:          o_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign ilim_code = ilim_q[`CCR_ILIM_HI:`CCR_ILIM_LO];
  assign vp_code   = ctrl_b_q[`CCR_PRECHARGE_RISE_THRESHOLD_HI:`CCR_PRECHARGE_RISE_THRESHOLD_LO];
  assign done_code = ctrl_b_q[`CCR_DONE_HI:`CCR_DONE_LO];

  // Decoded outputs, registered so analog controls see clean levels
  always @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      o_input_current_limit_sel <= 3'h0;
      o_input_limit_ma          <= 10'h000;
      o_battery_pulldown_enable <= 1'b0;
      o_precharge_rise_10mv     <= 9'h000;
      o_termination_pct         <= 5'h00;
      o_charger_enable          <= 1'b0;
      o_force_precharge_current <= 1'b0;
      o_restart_request         <= 1'b0;
    end else begin
      o_input_current_limit_sel <= ilim_code;
      o_input_limit_ma  <= ilim_table[ilim_code*10 +: 10];
      o_battery_pulldown_enable <= ctrl_b_q[`CCR_PULLDOWN_BIT];
      o_precharge_rise_10mv <= `CCR_VP_BASE
                               + `CCR_VP_STEP * {6'h00, vp_code};
      o_termination_pct <= done_table[done_code*5 +: 5];
      o_charger_enable  <= ctrl_a_q[`CCR_EN_BIT];
      // Force bit is ignored while the charger is off
      o_force_precharge_current <= ctrl_a_q[`CCR_FRC_PCHG_BIT]
                                   & ctrl_a_q[`CCR_EN_BIT];
      // Without auto-restart the charger stays parked in done
      o_restart_request <= timer_q[`CCR_RESTART_BIT] & i_maint_done
                           & i_vbat_below_recharge;
    end
  end
endmodule
`default_nettype wire

// [core/ccr_sync3.v]
// Purpose: Three-stage synchroniser with agreement check
// Assumes: Input is asynchronous to i_clk
// Notes:   Output changes only when stages two and three agree
`default_nettype none
module ccr_sync3 (
  // Clock and reset
  input  wire i_clk,
  input  wire i_rstn,
  // Data
  input  wire i_async,
  output reg  o_level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // Stage one is read only by stage two
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/ccr_regs_monitor.sv]
// Purpose: Port assertions for the charger register bank
// Assumes: Bench writes registers with option none, rise-only or fall-only selected
// Notes:   Range checks start two edges after reset release
`default_nettype none
module ccr_regs_monitor (
  input wire       I_CORE_CLK,
  input wire       I_RSTN,
  input wire       i_wr_en,
  input wire       i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_charger_supply_input,
  input wire [1:0] i_supply_valid_reset_option,
  input wire       i_maint_done,
  input wire       i_vbat_below_recharge,
  input wire [2:0] o_input_current_limit_sel,
  input wire [9:0] o_input_limit_ma,
  input wire       o_battery_pulldown_enable,
  input wire [8:0] o_precharge_rise_10mv,
  input wire [4:0] o_termination_pct,
  input wire       o_charger_enable,
  input wire       o_force_precharge_current,
  input wire       o_restart_request,
  input wire       o_rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  // Decode, range and write-through relations on the bank outputs
  a_ilim_top: assert property (
    o_input_current_limit_sel == 3'h7 |-> o_input_limit_ma == 10'd1000)
    else $error("ilim code 7 not 1000 mA");
  a_supply_dflt: assert property (
    $changed(i_charger_supply_input) && i_supply_valid_reset_option == 2'h0
    |-> ##[2:12] !o_charger_enable && !o_battery_pulldown_enable)
    else $error("supply edge did not restore defaults");
  a_pd_write: assert property (
    i_wr_en && i_addr == 8'h11 && i_supply_valid_reset_option == 2'h3
    |-> ##2 o_battery_pulldown_enable == $past(i_wdata[7], 2))
    else $error("pulldown not following write");
  a_vp_steps: assert property (
    $past(I_RSTN, 2) |-> o_precharge_rise_10mv inside {[9'd210:9'd315]}
    && (o_precharge_rise_10mv - 9'd210) % 15 == 0)
    else $error("precharge threshold off grid");
  a_done_set: assert property (
    $past(I_RSTN, 2) |-> o_termination_pct inside {5'd5, 5'd10, 5'd20, 5'd30})
    else $error("termination ratio illegal");
  a_restart_cause: assert property (
    o_restart_request |-> $past(i_maint_done && i_vbat_below_recharge))
    else $error("restart without done and low battery");
  a_force_gate: assert property (
    o_force_precharge_current |-> o_charger_enable)
    else $error("forced precharge while disabled");
  a_rd_pulse: assert property (
    $past(I_RSTN) |-> o_rd_valid == $past(i_rd_en))
    else $error("read valid not one cycle after strobe");
endmodule
bind ccr_regs ccr_regs_monitor ccr_regs_monitor_i (.*);
`default_nettype wire

// [dv/ccr_regs_tb.sv]
// Purpose: Self-checking bench for the charger register bank
// Assumes: Option none, rise-only or fall-only while registers are written
// Notes:   Expectations come from a byte model of the bank
`default_nettype none
`include "ccr_defs.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0d got %0d", n, e, s); end end
module ccr_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rstn = 0, we = 0, re = 0, sup = 0, md = 0, vb = 0;
  logic [7:0] ad = 0, wd = 0;
  logic [1:0] opt = 2'h3;
  wire  [7:0] rdat;
  wire  [9:0] ma;
  wire  [8:0] vp;
  wire  [4:0] pct;
  wire  [2:0] sel;
  wire        rv, pd, en, frc, rst;
  int         n_fail = 0, tests_run = 0, i, mdl[5];
  int         ilim_t[8] = '{50, 90, 150, 200, 300, 400, 450, 1000};
  int         pct_t[4] = '{5, 10, 20, 30};
  bit [31:0]  seed = 30631, r;
  ccr_regs ccr_regs_i (.I_CORE_CLK(clk), .I_RSTN(rstn), .i_wr_en(we),
    .i_rd_en(re), .i_addr(ad), .i_wdata(wd), .o_rdata(rdat), .o_rd_valid(rv),
    .i_charger_supply_input(sup), .i_supply_valid_reset_option(opt),
    .i_maint_done(md), .i_vbat_below_recharge(vb),
    .o_input_current_limit_sel(sel), .o_input_limit_ma(ma),
    .o_battery_pulldown_enable(pd), .o_precharge_rise_10mv(vp),
    .o_termination_pct(pct), .o_charger_enable(en),
    .o_force_precharge_current(frc), .o_restart_request(rst));
  // Free-running core clock
  always #4 clk = ~clk;
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic dflt();
    mdl = '{`CCR_RST_ILIM, `CCR_RST_CTRL_A, `CCR_RST_CTRL_B, `CCR_RST_TIMER,
      `CCR_RST_STEP_A};
  endtask
  // Unmapped writes are dropped, bit 7 of the last register is fixed at 0
  task automatic wr(input bit [7:0] a, input bit [7:0] d);
    @(posedge clk) begin we <= 1; ad <= a; wd <= d; end
    @(posedge clk) we <= 0;
    if (a inside {[8'h0f:8'h13]}) mdl[a-8'h0f] = d & (a == 8'h13 ? 'h7f : 'hff);
  endtask
  task automatic rd(input bit [7:0] a);
    @(posedge clk) begin re <= 1; ad <= a; end
    @(posedge clk) re <= 0;
    #1;
    `CHK("rd_valid", 1, rv)
    @(posedge clk) #1;
    `CHK("rdata", (a inside {[8'h0f:8'h13]}) ? mdl[a-8'h0f] : 0, rdat)
  endtask
  // Decoded outputs settle two edges after the last write
  task automatic dec();
    int c, b;
    repeat (2) @(posedge clk);
    #1;
    c = mdl[0];
    b = mdl[2];
    `CHK("ilim", ilim_t[c[2:0]], ma)
    `CHK("ilim_sel", c[2:0], sel)
    `CHK("enable", mdl[1][0], en)
    `CHK("pulldown", b[7], pd)
    `CHK("vp", 210 + 15 * b[6:4], vp)
    `CHK("pct", pct_t[b[1:0]], pct)
    `CHK("force", mdl[1][7] & mdl[1][0], frc)
    `CHK("restart", mdl[3][6] & md & vb, rst)
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence: defaults, every code, random traffic, supply edges
  initial begin
    dflt();
    repeat (20) @(posedge clk);
    rstn <= 1;
    for (i = 0; i < 7; i++) rd(8'h0e + i[7:0]);
    dec();
    $display("test defaults done");
    for (i = 0; i < 8; i++) begin
      wr(8'h0f, 8'(i));
      wr(8'h11, 8'(i * 17 + i[0] * 128));
      dec();
    end
    $display("test codes done");
    for (i = 0; i < 60; i++) begin
      r = rnd();
      @(posedge clk) begin md <= r[8]; vb <= r[9]; end
      wr(8'h0e + 8'(r[2:0] % 7), r[23:16]);
      rd(8'h0e + 8'(r[5:3] % 7));
      dec();
    end
    $display("test random done");
    wr(8'h11, 8'h80);
    wr(8'h10, 8'h81);
    @(posedge clk) begin opt <= 2'h0; sup <= 1; end
    repeat (12) @(posedge clk);
    dflt();
    dec();
    rd(8'h10);
    @(posedge clk) opt <= 2'h3;
    wr(8'h11, 8'h80);
    @(posedge clk) sup <= 0;
    repeat (12) @(posedge clk);
    dec();
    $display("test supply done");
    // Rise-only option: rising edge reloads, falling edge keeps
    @(posedge clk) opt <= 2'h1;
    wr(8'h11, 8'h80);
    @(posedge clk) sup <= 1;
    repeat (12) @(posedge clk);
    dflt();
    dec();
    wr(8'h11, 8'h80);
    @(posedge clk) sup <= 0;
    repeat (12) @(posedge clk);
    dec();
    // Fall-only option: rising edge keeps, falling edge reloads
    @(posedge clk) opt <= 2'h2;
    wr(8'h11, 8'h80);
    @(posedge clk) sup <= 1;
    repeat (12) @(posedge clk);
    dec();
    @(posedge clk) sup <= 0;
    repeat (12) @(posedge clk);
    dflt();
    dec();
    $display("test option done");
    complete_run();
  end
  // Watchdog far beyond the roughly 700 cycles the tests need
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
